/* common/aac_pkg.sv */
// aac_pkg: constants and types for the auxiliary converter control block.
// assumes a 250 MHz core clock and a 16-bit register port.
package aac_pkg;

    // register port
    localparam int REG_AW = 16;
    localparam int REG_DW = 16;

    // register addresses
    localparam logic [15:0] ADDR_DATA    = 16'h402D;
    localparam logic [15:0] ADDR_CTRL    = 16'h402E;
    localparam logic [15:0] ADDR_SRC     = 16'h402F;
    localparam logic [15:0] ADDR_IRQ_STS = 16'h4030;
    localparam logic [15:0] ADDR_IRQ_CLR = 16'h4031;
    localparam logic [15:0] ADDR_IRQ_EN  = 16'h4032;

    // control register fields
    localparam int CTRL_ON_BIT  = 15;
    localparam int CTRL_GO_BIT  = 14;
    localparam int CTRL_SLP_BIT = 12;
    localparam int RATE_LSB     = 0;
    localparam int RATE_W       = 6;

    // rate codes
    localparam logic [5:0] RATE_MANUAL   = 6'h00;
    localparam logic [5:0] RATE_RESERVED = 6'h20;
    localparam int         RATE_FINE_STEP   = 2;
    localparam int         RATE_COARSE_STEP = 16;
    localparam int         RATE_HZ_W        = 9;

    // sources and data register layout
    localparam int         SRC_COUNT    = 10;
    localparam int         SRC_W        = 4;
    localparam int         RESULT_W     = 12;
    localparam int         DATA_SRC_LSB = 12;
    localparam int         SRC_EXT_COUNT = 4;
    // select bit scanned last: chip temperature
    localparam logic [3:0] SRC_LAST     = 4'h4;

    // interrupt bits
    localparam int IRQ_W       = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_OVR_BIT  = 1;

    // reset values
    localparam logic [5:0]  RATE_RST   = 6'h00;
    localparam logic [9:0]  SRC_RST    = 10'h000;
    localparam logic [15:0] DATA_RST   = 16'h0000;
    localparam logic [1:0]  IRQ_EN_RST = 2'h0;
    localparam logic [1:0]  IRQ_STS_RST = 2'h0;

    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_HZ_DEF    = 1000000000 / CLK_PERIOD_NS;
    localparam int ACC_W         = 29;

    typedef enum logic [1:0] {
        PWR_OFF   = 2'b00,
        PWR_ON    = 2'b01,
        PWR_SLEEP = 2'b10
    } aac_pwr_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } aac_fsm_e;

endpackage

/* rtl/aac_rate_tick.sv */
// aac_rate_tick: one-cycle trigger pulses at the selected sample rate.
// assumes clk at clk_hz; run low holds the accumulator at zero.
`timescale 1ns/100ps
`default_nettype none
module aac_rate_tick #(
    parameter logic [aac_pkg::ACC_W-1:0] CLK_HZ = aac_pkg::ACC_W'(aac_pkg::CLK_HZ_DEF)
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // control
    input  wire logic                      run,
    input  wire logic [aac_pkg::RATE_W-1:0] rate_code,
    // trigger
    output logic                           tick
);
    import aac_pkg::*;

    logic [RATE_HZ_W-1:0] rate_hz;
    logic [ACC_W-1:0]     acc_r;
    logic [ACC_W-1:0]     acc_sum;

    // fine codes step by 2/s, coarse codes by 16/s, reserved gives none
    always_comb begin
        if (rate_code < RATE_RESERVED) begin
            rate_hz = RATE_HZ_W'(int'(rate_code) * RATE_FINE_STEP); // R11
        end else if (rate_code == RATE_RESERVED) begin
            rate_hz = '0; // R11
        end else begin
            rate_hz = RATE_HZ_W'((int'(rate_code) - int'(RATE_RESERVED)) * RATE_COARSE_STEP); // R11
        end
    end

    assign acc_sum = acc_r + ACC_W'(rate_hz);

    // fractional accumulator: exact average rate without a divider
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            acc_r <= '0;
            tick  <= 1'b0;
        end else if (acc_sum >= CLK_HZ) begin
            acc_r <= acc_sum - CLK_HZ;
            tick  <= 1'b1; // R04
        end else begin
            acc_r <= acc_sum;
            tick  <= 1'b0;
        end
    end

endmodule // aac_rate_tick
`default_nettype wire

/* rtl/aac_src_pick.sv */
// aac_src_pick: finds the next enabled source after the last one measured.
// purely combinational; scans inputs 1-4, then adapter down to chip temp.
`timescale 1ns/100ps
`default_nettype none
module aac_src_pick (
    // source state
    input  wire logic [aac_pkg::SRC_COUNT-1:0] src_mask,
    input  wire logic [aac_pkg::SRC_W-1:0]     last_idx,
    // result
    output logic [aac_pkg::SRC_W-1:0]          next_idx,
    output logic                               found
);
    import aac_pkg::*;

    // scan position to select bit; the mapping is its own inverse
    function automatic int scan_bit(input int pos);
        return (pos < SRC_EXT_COUNT) ? pos : SRC_COUNT + SRC_EXT_COUNT - 1 - pos; // R10
    endfunction

    always_comb begin
        int first_pos;
        int pos;
        int sel;
        first_pos = scan_bit(int'(last_idx));
        pos       = 0;
        sel       = 0;
        found     = 1'b0;
        next_idx  = last_idx;
        // descending so the nearest enabled source wins
        for (int k = SRC_COUNT; k >= 1; k--) begin
            pos = (first_pos + k) % SRC_COUNT;
            sel = scan_bit(pos);
            if (src_mask[sel]) begin
                next_idx = SRC_W'(sel); // R08
                found    = 1'b1;
            end
        end
    end

endmodule // aac_src_pick
`default_nettype wire

/* rtl/aac_ctrl.sv */
// aac_ctrl: register file, trigger logic and source sequencer of the
// auxiliary converter. assumes an external converter that answers each
// conv_start pulse with one conv_done pulse carrying the result.
//
// Summary of operation
// R01 - each measurement yields a 12-bit unsigned result code.
// R02 - converter runs only with converter_on set; OFF state clears it.
// R03 - in SLEEP the converter is off unless sleep_keep_on is set.
// R04 - nonzero rate with conversion_go set gives periodic automatic conversions.
// R05 - rate zero: each conversion_go write starts one conversion, then self-clears.
// R06 - software trusts a result only after the completion interrupt.
// R07 - ten sources, each with its own enable bit, any combination.
// R08 - every trigger advances to the next enabled source, cycling round.
// R09 - each trigger makes exactly one measurement on one source.
// R10 - inputs 1, battery, USB enabled: three triggers measure them in order.
// R11 - rate code 0 manual, 1-31 2..62/s, 32 reserved, 33-63 16..496/s.
// R12 - source bits: 9 adapter down to 0 external input 1, reset zero.
// R13 - data register holds source code 15:12 and result 11:0, overwritten.
// R14 - with converter_on clear, triggers are ignored and the pointer rewinds.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module aac_ctrl #(
    parameter int unsigned CLK_HZ = aac_pkg::CLK_HZ_DEF
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // register port
    input  wire logic [aac_pkg::REG_AW-1:0]   reg_addr,
    input  wire logic [aac_pkg::REG_DW-1:0]   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [aac_pkg::REG_DW-1:0]   reg_rdata,
    // power state of the device
    input  wire logic [1:0]                   power_state,
    // converter core
    output logic                              aux_converter_power,
    output logic                              conv_start,
    output logic      [aac_pkg::SRC_W-1:0]    conv_source,
    input  wire logic                         conv_done,
    input  wire logic [aac_pkg::RESULT_W-1:0] conv_result,
    // interrupt
    output logic                              irq
);
    import aac_pkg::*;

    // control register
    logic                 converter_on_r;
    logic                 conversion_go_r;
    logic                 sleep_keep_on_r;
    logic [RATE_W-1:0]    rate_r;
    // source select, data, interrupts
    logic [SRC_COUNT-1:0] src_sel_r;
    logic [REG_DW-1:0]    data_r;
    logic                 unread_r;
    logic [IRQ_W-1:0]     irq_sts_r;
    logic [IRQ_W-1:0]     irq_en_r;
    // sequencer
    aac_fsm_e             state_r;
    logic [SRC_W-1:0]     ptr_r;

    logic                 wr_ctrl;
    logic                 wr_src;
    logic                 wr_clr;
    logic                 wr_en;
    logic                 rd_data;
    logic                 in_off;
    logic                 active;
    logic                 manual_mode;
    logic                 auto_run;
    logic                 auto_tick;
    logic                 manual_req;
    logic                 trigger;
    logic                 launch;
    logic                 store;
    logic                 manual_end;
    logic [SRC_W-1:0]     next_idx;
    logic                 found;
    logic [IRQ_W-1:0]     irq_evt;
    logic [IRQ_W-1:0]     irq_clr;

    // register decode
    assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    assign wr_src  = reg_wr && (reg_addr == ADDR_SRC);
    assign wr_clr  = reg_wr && (reg_addr == ADDR_IRQ_CLR);
    assign wr_en   = reg_wr && (reg_addr == ADDR_IRQ_EN);
    assign rd_data = reg_rd && (reg_addr == ADDR_DATA);

    // power gating of the converter
    assign in_off = (power_state == PWR_OFF);
    assign active = converter_on_r && !in_off // R02
                    && ((power_state != PWR_SLEEP) || sleep_keep_on_r); // R03

    assign aux_converter_power = active;

    // trigger sources
    assign manual_mode = (rate_r == RATE_MANUAL);
    assign auto_run    = active && conversion_go_r && !manual_mode; // R04
    assign manual_req  = conversion_go_r && manual_mode; // R05
    assign trigger     = active && (manual_req || auto_tick); // R14

    // one launch per trigger, only from idle
    assign launch = trigger && found && (state_r == ST_IDLE); // R09
    assign store  = (state_r == ST_BUSY) && active && conv_done;

    // manual bit drops when its conversion lands or cannot run
    assign manual_end = manual_req && (state_r == ST_IDLE)
                        ? (!active || !found)
                        : (store && manual_mode); // R05

    aac_rate_tick #(
        .CLK_HZ    (ACC_W'(CLK_HZ))
    ) u_rate (
        .clk       (clk),
        .rst_n     (rst_n),
        .run       (auto_run),
        .rate_code (rate_r),
        .tick      (auto_tick)
    );

    aac_src_pick u_pick (
        .src_mask  (src_sel_r),
        .last_idx  (ptr_r),
        .next_idx  (next_idx),
        .found     (found)
    );

    // converter_on, sleep_keep_on and rate fields
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            converter_on_r  <= 1'b0;
            sleep_keep_on_r <= 1'b0;
            rate_r          <= RATE_RST;
        end else begin
            if (wr_ctrl) begin
                converter_on_r  <= reg_wdata[CTRL_ON_BIT];
                sleep_keep_on_r <= reg_wdata[CTRL_SLP_BIT]; // R03
                rate_r          <= reg_wdata[RATE_LSB +: RATE_W]; // R11
            end
            // OFF overrides a converter_on write in the same cycle
            if (in_off) begin
                converter_on_r <= 1'b0; // R02
            end
        end
    end

    // conversion_go: a software write wins over the self-clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conversion_go_r <= 1'b0;
        end else if (wr_ctrl) begin
            conversion_go_r <= reg_wdata[CTRL_GO_BIT]; // R04
        end else if (manual_end) begin
            conversion_go_r <= 1'b0; // R05
        end
    end

    // source select register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_sel_r <= SRC_RST; // R12
        end else if (wr_src) begin
            src_sel_r <= reg_wdata[SRC_COUNT-1:0]; // R07
        end
    end

    // sequencer and source pointer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r     <= ST_IDLE;
            ptr_r       <= SRC_LAST;
            conv_start  <= 1'b0;
            conv_source <= '0;
        end else begin
            conv_start <= 1'b0;
            if (!active) begin
                // rewind so the first enabled source comes next
                state_r <= ST_IDLE;
                ptr_r   <= SRC_LAST; // R14
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        if (launch) begin
                            ptr_r       <= next_idx; // R08
                            conv_source <= next_idx + 4'h1; // R12
                            conv_start  <= 1'b1; // R09
                            state_r     <= ST_BUSY;
                        end
                    end
                    ST_BUSY: begin
                        if (conv_done) begin
                            state_r <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // data register: source code above the result
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_r <= DATA_RST;
        end else if (store) begin
            data_r <= {conv_source, conv_result}; // R13 R01
        end
    end

    // sample not yet read; a new sample wins over the read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            unread_r <= 1'b0;
        end else if (store) begin
            unread_r <= 1'b1;
        end else if (rd_data) begin
            unread_r <= 1'b0;
        end
    end

    // interrupt events
    always_comb begin
        irq_evt               = '0;
        irq_evt[IRQ_DONE_BIT] = store; // R06
        irq_evt[IRQ_OVR_BIT]  = store && unread_r && !rd_data;
    end

    assign irq_clr = wr_clr ? reg_wdata[IRQ_W-1:0] : '0;

    // sticky status, set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_sts_r <= IRQ_STS_RST;
        end else begin
            irq_sts_r <= (irq_sts_r & ~irq_clr) | irq_evt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_en_r <= IRQ_EN_RST;
        end else if (wr_en) begin
            irq_en_r <= reg_wdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_sts_r & irq_en_r);

    // read data, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_DATA: begin
                    reg_rdata <= data_r;
                end
                ADDR_CTRL: begin
                    reg_rdata <= '0;
                    reg_rdata[CTRL_ON_BIT]  <= converter_on_r;
                    reg_rdata[CTRL_GO_BIT]  <= conversion_go_r;
                    reg_rdata[CTRL_SLP_BIT] <= sleep_keep_on_r;
                    reg_rdata[RATE_LSB +: RATE_W] <= rate_r;
                end
                ADDR_SRC: begin
                    reg_rdata <= {6'h00, src_sel_r};
                end
                ADDR_IRQ_STS: begin
                    reg_rdata <= {14'h0000, irq_sts_r};
                end
                ADDR_IRQ_EN: begin
                    reg_rdata <= {14'h0000, irq_en_r};
                end
                default: begin
                    reg_rdata <= '0;
                end
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule // aac_ctrl
`default_nettype wire

/* testbench/aac_ctrl_assertions.sv */
// aac_ctrl_assertions: port-level checks on the converter control block.
// assumes binding to aac_ctrl; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module aac_ctrl_assertions
    import aac_pkg::*;
(
    // clock and reset
    input wire logic                         clk,
    input wire logic                         rst_n,
    // register port
    input wire logic [aac_pkg::REG_AW-1:0]   reg_addr,
    input wire logic [aac_pkg::REG_DW-1:0]   reg_wdata,
    input wire logic                         reg_wr,
    input wire logic                         reg_rd,
    input wire logic [aac_pkg::REG_DW-1:0]   reg_rdata,
    // power and converter
    input wire logic [1:0]                   power_state,
    input wire logic                         aux_converter_power,
    input wire logic                         conv_start,
    input wire logic [aac_pkg::SRC_W-1:0]    conv_source,
    input wire logic                         conv_done,
    input wire logic [aac_pkg::RESULT_W-1:0] conv_result,
    input wire logic                         irq
);
    logic slp_r;

    // shadow of the sleep keep bit
    always_ff @(posedge clk) begin
        if (!rst_n) slp_r <= 1'b0;
        else if (reg_wr && reg_addr == ADDR_CTRL) slp_r <= reg_wdata[CTRL_SLP_BIT];
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_start_pulse; conv_start |=> !conv_start; endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("conv_start longer than one cycle");
    property p_off; (power_state == PWR_OFF) [*2] |-> !aux_converter_power; endproperty
    a_off: assert property (p_off)
        else $error("converter powered in OFF state");
    property p_sleep; power_state == PWR_SLEEP && !slp_r |-> !aux_converter_power; endproperty
    a_sleep: assert property (p_sleep)
        else $error("converter powered in SLEEP without keep bit");
    property p_on_clr;
        reg_wr && reg_addr == ADDR_CTRL && !reg_wdata[CTRL_ON_BIT] |=> !aux_converter_power;
    endproperty
    a_on_clr: assert property (p_on_clr)
        else $error("converter powered after enable cleared");
    property p_no_start_off;
        reg_wr && reg_addr == ADDR_CTRL && !reg_wdata[CTRL_ON_BIT] |-> ##2 !conv_start [*2];
    endproperty
    a_no_start_off: assert property (p_no_start_off)
        else $error("start while converter disabled");
    property p_start_src; conv_start |-> conv_source >= 4'h1 && conv_source <= 4'hA; endproperty
    a_start_src: assert property (p_start_src)
        else $error("start with source code out of range");
    property p_src_hold; !conv_start |-> $stable(conv_source); endproperty
    a_src_hold: assert property (p_src_hold)
        else $error("source code moved without a start");
    property p_start_active; conv_start |-> $past(aux_converter_power); endproperty
    a_start_active: assert property (p_start_active)
        else $error("start launched while inactive");
    property p_data_src; reg_rd && reg_addr == ADDR_DATA |=> reg_rdata[15:12] <= 4'hA; endproperty
    a_data_src: assert property (p_data_src)
        else $error("data source code out of range");
    property p_ctrl_rsvd;
        reg_rd && reg_addr == ADDR_CTRL |=> reg_rdata[13] == 1'b0 && reg_rdata[11:6] == 6'h00;
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd)
        else $error("control unused bits read nonzero");
    property p_src_rsvd; reg_rd && reg_addr == ADDR_SRC |=> reg_rdata[15:10] == 6'h00; endproperty
    a_src_rsvd: assert property (p_src_rsvd)
        else $error("source select unused bits read nonzero");
endmodule // aac_ctrl_assertions

bind aac_ctrl aac_ctrl_assertions chk_u (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_state(power_state),
    .aux_converter_power(aux_converter_power), .conv_start(conv_start),
    .conv_source(conv_source), .conv_done(conv_done), .conv_result(conv_result), .irq(irq)
);
`default_nettype wire

/* testbench/aac_ctrl_tb_top.sv */
// aac_ctrl_tb_top: self-checking bench for the converter control block.
// assumes a small CLK_HZ so automatic ticks come every 500 or 62.5 cycles.
`timescale 1ns/100ps
`default_nettype none
module aac_ctrl_tb_top;
    import aac_pkg::*;
    localparam int unsigned HZ = 1000;
    logic        clk, rst_n, reg_wr, reg_rd, conv_start, irq, pwr_on;
    logic        conv_done = 1'b0;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [1:0]  power_state;
    logic [3:0]  conv_source;
    logic [11:0] conv_result = 12'h000;
    int          n_errors, total_checks, i, n;
    int          dly = 0;
    int          cyc = 0;
    int          st_t[$];
    logic [15:0] ra[5] = '{ADDR_CTRL, ADDR_SRC, ADDR_DATA, ADDR_IRQ_EN, 16'h0000};
    logic [5:0]  rt[2] = '{6'h01, 6'h21};
    logic [15:0] gp[2] = '{16'h03E8, 16'h007D};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    aac_ctrl #(.CLK_HZ(HZ)) dut_u (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_state(power_state),
        .aux_converter_power(pwr_on), .conv_start(conv_start), .conv_source(conv_source),
        .conv_done(conv_done), .conv_result(conv_result), .irq(irq)
    );

    // converter stand-in: done four cycles after each start
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (conv_start) st_t.push_back(cyc);
        dly <= conv_start ? 3 : (dly > 0 ? dly - 1 : 0);
        conv_done <= (dly == 1);
        conv_result <= 12'hA50 | {8'h00, conv_source};
    end

    task close_out();
        $display("Checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [15:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rv = reg_rdata;
    endtask

    task wait_starts(input int cnt);
        int k;
        for (k = 0; k < 2500 && st_t.size() < cnt; k++) @(posedge clk);
        if (st_t.size() < cnt) begin
            n_errors++;
            $display("Error start count expected %0d seen %0d", cnt, st_t.size());
            close_out();
        end
    endtask

    // one manual conversion with its readback
    task manual(input logic [3:0] src, input logic ex_irq);
        int s;
        s = st_t.size();
        wr(ADDR_CTRL, 16'hC000);
        wait_starts(s + 1);
        chk("conv_source", {12'h000, conv_source}, {12'h000, src});
        repeat (8) @(posedge clk);
        rd(ADDR_CTRL);
        chk("ctrl_go", rv, 16'h8000);
        chk("irq", {15'h0000, irq}, {15'h0000, ex_irq});
        rd(ADDR_DATA);
        chk("data", rv, {src, 12'hA50 | {8'h00, src}});
        wr(ADDR_IRQ_CLR, 16'h0003);
        @(negedge clk);
        chk("irq_clr", {15'h0000, irq}, 16'h0000);
        chk("n_starts", 16'(st_t.size() - s), 16'h0001);
    endtask

    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        power_state = PWR_ON;
        n_errors = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i++) begin
            rd(ra[i]);
            chk("reset", rv, 16'h0000);
        end
        wr(ADDR_IRQ_EN, 16'h0001);
        wr(ADDR_SRC, 16'h0181);
        rd(ADDR_SRC);
        chk("src", rv, 16'h0181);
        manual(4'h1, 1'b1);
        manual(4'h9, 1'b1);
        manual(4'h8, 1'b1);
        // go without enable must be dropped and rewind the pointer
        wr(ADDR_CTRL, 16'h0000);
        wr(ADDR_CTRL, 16'h4000);
        repeat (10) @(posedge clk);
        rd(ADDR_CTRL);
        chk("ctrl_off", rv, 16'h0000);
        chk("no_start", 16'(st_t.size()), 16'h0003);
        wr(ADDR_IRQ_EN, 16'h0000);
        wr(ADDR_SRC, 16'h03FF);
        // inputs 1-4 first, then adapter down to chip temperature
        for (i = 0; i <= 10; i++) begin
            n = i % 10;
            manual(4'(n < 4 ? n + 1 : 14 - n), 1'b0);
        end
        wr(ADDR_SRC, 16'h0001);
        for (i = 0; i < 2; i++) begin
            n = st_t.size();
            wr(ADDR_CTRL, 16'hC000 | {10'h000, rt[i]});
            wait_starts(n + 4);
            chk("tick_gap", 16'(st_t[n + 3] - st_t[n + 1]), gp[i]);
            wr(ADDR_CTRL, 16'h8000);
        end
        rd(ADDR_IRQ_STS);
        chk("irq_sts", rv, 16'h0003);
        n = st_t.size();
        wr(ADDR_CTRL, 16'hC020);
        repeat (600) @(posedge clk);
        chk("rsvd_rate", 16'(st_t.size() - n), 16'h0000);
        power_state <= PWR_SLEEP;
        wr(ADDR_CTRL, 16'h8000);
        @(negedge clk);
        chk("sleep_off", {15'h0000, pwr_on}, 16'h0000);
        wr(ADDR_CTRL, 16'h9000);
        @(negedge clk);
        chk("sleep_keep", {15'h0000, pwr_on}, 16'h0001);
        @(posedge clk);
        power_state <= PWR_OFF;
        repeat (3) @(posedge clk);
        rd(ADDR_CTRL);
        chk("off_clear", rv, 16'h1000);
        chk("off_power", {15'h0000, pwr_on}, 16'h0000);
        close_out();
    end
endmodule // aac_ctrl_tb_top
`default_nettype wire
